// ==== verilog/l4_port_flag_matcher.sv ====
/*
  Layer-4 part of one access_rule_entry: source/destination port filters and the
  FIN, SYN and RST flag filters, with an AHB-Lite register slave.
  Assumes the ingress parser presents one frame's header fields with frame_valid
  for one cycle, and that these inputs are synchronous to mclk.
*/
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "l4_match_defines.svh"

// Operation
// R1: source don't-care: the source port never affects the match.
// R2: source exact: match only when the source port equals the configured value.
// R3: source range: match only when the source port lies inside the range.
// R4: destination don't-care: the destination port is ignored.
// R5: destination exact: match only when the destination port equals the value.
// R6: destination range: match only when the destination port lies in the range.
// R7: FIN 0 rejects FIN set, 1 requires FIN set, don't-care ignores FIN.
// R8: SYN 0 rejects SYN set, 1 requires SYN set, don't-care ignores SYN.
// R9: RST setting 0 keeps TCP frames with RST set from matching.
// R10: RST 1 requires RST set; don't-care ignores RST.
// R11: bounds inclusive; port filters only on TCP/UDP; all conditions must hold.
module l4_port_flag_matcher (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                frame_valid,
  input  wire logic                frame_is_tcp,
  input  wire logic                frame_is_udp,
  input  wire l4_match_pkg::port_t frame_src_port,
  input  wire l4_match_pkg::port_t frame_dst_port,
  input  wire logic                frame_fin,
  input  wire logic                frame_syn,
  input  wire logic                frame_rst,
  output logic                     match_valid,
  output logic                     match_hit
);
  import l4_match_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] src_reg;
  logic [31:0] dst_reg;
  logic [5:0]  flags_reg;
  logic [31:0] count_reg;
  logic        last_hit_reg;
  bus_state_e  bus_state_reg;
  bus_state_e  bus_state_next;
  logic        wr_pend;
  logic [7:0]  addr_reg;
  logic        src_hit;
  logic        dst_hit;
  logic        flags_ok;
  logic        is_l4;
  logic        hit_next;
  logic        entry_en;
  logic [31:0] rdata_next;

  port_cmp_if src_if ();
  port_cmp_if dst_if ();

  function automatic logic flag_ok(input logic [1:0] setting, input logic bit_val);
    case (setting)
      `L4_FLAG_CLEAR: flag_ok = !bit_val;
      `L4_FLAG_SET:   flag_ok = bit_val;
      default:        flag_ok = 1'b1;
    endcase
  endfunction

  // code 3 is reserved and reads as don't-care, the same as flag_ok treats it
  function automatic logic flag_ignored(input logic [1:0] setting);
    flag_ignored = (setting == `L4_FLAG_ANY) || (setting == 2'h3);
  endfunction

  // reserved port mode counts as don't-care, as in the comparator
  function automatic logic port_ignored(input port_mode_e mode);
    port_ignored = (mode == PORT_ANY) || (mode == PORT_RSVD);
  endfunction

  // an address phase that starts a transfer, in either direction
  function automatic logic xfer_start(input logic sel, input logic [1:0] trans);
    xfer_start = sel && trans[1];
  endfunction

  assign src_if.mode = port_mode_e'(ctrl_reg[`L4_CTRL_SRC_MODE_LSB +: 2]);  // see R1
  assign src_if.lo   = src_reg[`L4_PORT_LO_LSB +: 16];                      // see R2
  assign src_if.hi   = src_reg[`L4_PORT_HI_LSB +: 16];                      // see R3
  assign src_if.port = frame_src_port;
  assign dst_if.mode = port_mode_e'(ctrl_reg[`L4_CTRL_DST_MODE_LSB +: 2]);  // see R4
  assign dst_if.lo   = dst_reg[`L4_PORT_LO_LSB +: 16];                      // see R5
  assign dst_if.hi   = dst_reg[`L4_PORT_HI_LSB +: 16];                      // see R6
  assign dst_if.port = frame_dst_port;

  port_cmp u_src_cmp (
    .pc (src_if.cmp)
  );

  port_cmp u_dst_cmp (
    .pc (dst_if.cmp)
  );

  assign src_hit  = src_if.hit;
  assign dst_hit  = dst_if.hit;
  assign is_l4    = frame_is_tcp || frame_is_udp;
  assign entry_en = ctrl_reg[`L4_CTRL_ENABLE_BIT];

  // flag filters only make sense for TCP; a non-TCP frame passes only if all three are don't-care
  always_comb begin
    if (frame_is_tcp) begin
      flags_ok = flag_ok(flags_reg[`L4_FLAG_FIN_LSB +: 2], frame_fin)    // see R7
               && flag_ok(flags_reg[`L4_FLAG_SYN_LSB +: 2], frame_syn)   // see R8
               && flag_ok(flags_reg[`L4_FLAG_RST_LSB +: 2], frame_rst);  // see R9 see R10
    end else begin
      flags_ok = flag_ignored(flags_reg[`L4_FLAG_FIN_LSB +: 2])
               && flag_ignored(flags_reg[`L4_FLAG_SYN_LSB +: 2])
               && flag_ignored(flags_reg[`L4_FLAG_RST_LSB +: 2]);
    end
  end

  // a port filter set to exact or range cannot be met by a frame without TCP/UDP ports
  always_comb begin
    hit_next = entry_en && flags_ok                                       // see R11
             && (is_l4 ? (src_hit && dst_hit)
                       : (port_ignored(src_if.mode) && port_ignored(dst_if.mode)));
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      match_valid <= 1'b0;
      match_hit   <= 1'b0;
    end else begin
      match_valid <= frame_valid;
      match_hit   <= frame_valid && hit_next;
    end
  end

  // bus slave: zero wait states, writes land in the data phase
  always_comb begin
    bus_state_next = BUS_IDLE;
    if (xfer_start(hsel, htrans)) begin
      bus_state_next = hwrite ? BUS_WRITE : BUS_READ;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bus_state_reg <= BUS_IDLE;
      addr_reg      <= 8'h00;
    end else if (hready) begin
      bus_state_reg <= bus_state_next;
      addr_reg      <= haddr[7:0];
    end
  end

  // reads need nothing in the data phase; their data was latched at the address phase
  always_comb begin
    case (bus_state_reg)
      BUS_WRITE: wr_pend = 1'b1;
      default:   wr_pend = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_reg  <= `L4_CTRL_RESET;
      src_reg   <= `L4_PORT_RESET;
      dst_reg   <= `L4_PORT_RESET;
      flags_reg <= `L4_FLAGS_RESET;
    end else if (wr_pend && hready) begin
      case (addr_reg)
        `L4_OFF_CTRL:     ctrl_reg  <= {27'h0000000, hwdata[4:0]};
        `L4_OFF_SRC_PORT: src_reg   <= hwdata;
        `L4_OFF_DST_PORT: dst_reg   <= hwdata;
        `L4_OFF_FLAGS:    flags_reg <= hwdata[5:0];
        default:          ;
      endcase
    end
  end

  // hit counter saturates rather than wrapping, so a long run never reads as few hits
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count_reg    <= 32'h0000_0000;
      last_hit_reg <= 1'b0;
    end else if (match_valid) begin
      last_hit_reg <= match_hit;
      if (match_hit && count_reg != 32'hFFFF_FFFF) begin
        count_reg <= count_reg + 32'h0000_0001;
      end
    end
  end

  always_comb begin
    case (haddr[7:0])
      `L4_OFF_CTRL:     rdata_next = ctrl_reg;
      `L4_OFF_SRC_PORT: rdata_next = src_reg;
      `L4_OFF_DST_PORT: rdata_next = dst_reg;
      `L4_OFF_FLAGS:    rdata_next = {26'h0000000, flags_reg};
      `L4_OFF_STATUS:   rdata_next = {31'h00000000, last_hit_reg};
      `L4_OFF_COUNT:    rdata_next = count_reg;
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  // read data is latched at the address phase and stands through the data phase
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && xfer_start(hsel, htrans) && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end
endmodule

// ==== pkg/l4_match_defines.svh ====
/*
  Register offsets, field positions, reset values and encodings of the layer-4 port and flag matcher.
  Assumes it is included by its bare name from the package and the design files.
*/
`ifndef L4_MATCH_DEFINES_SVH
`define L4_MATCH_DEFINES_SVH

`define L4_OFF_CTRL      8'h00
`define L4_OFF_SRC_PORT  8'h04
`define L4_OFF_DST_PORT  8'h08
`define L4_OFF_FLAGS     8'h0C
`define L4_OFF_STATUS    8'h10
`define L4_OFF_COUNT     8'h14

`define L4_CTRL_SRC_MODE_LSB  0
`define L4_CTRL_DST_MODE_LSB  2
`define L4_CTRL_ENABLE_BIT    4

`define L4_FLAG_FIN_LSB  0
`define L4_FLAG_SYN_LSB  2
`define L4_FLAG_RST_LSB  4

`define L4_PORT_LO_LSB   0
`define L4_PORT_HI_LSB   16

`define L4_CTRL_RESET    32'h0000_0000
`define L4_PORT_RESET    32'hFFFF_0000
`define L4_FLAGS_RESET   6'h3F

`define L4_PORT_ANY      2'h0
`define L4_PORT_EXACT    2'h1
`define L4_PORT_RANGE    2'h2

`define L4_FLAG_CLEAR    2'h0
`define L4_FLAG_SET      2'h1
`define L4_FLAG_ANY      2'h2

`endif

// ==== pkg/l4_match_pkg.sv ====
/*
  Types shared by the matcher top and its port comparator.
  Assumes l4_match_defines.svh is on the include path.
*/
`include "l4_match_defines.svh"

package l4_match_pkg;

  typedef enum logic [1:0] {
    PORT_ANY   = 2'b00,
    PORT_EXACT = 2'b01,
    PORT_RANGE = 2'b10,
    PORT_RSVD  = 2'b11
  } port_mode_e;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_state_e;

  typedef logic [15:0] port_t;

endpackage

// ==== pkg/port_cmp_if.sv ====
/*
  Carries one port filter's settings and result between the matcher top and a comparator.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps

interface port_cmp_if;
  import l4_match_pkg::*;
  port_mode_e mode;
  port_t      lo;
  port_t      hi;
  port_t      port;
  logic       hit;

  modport owner (output mode, output lo, output hi, output port, input hit);
  modport cmp   (input mode, input lo, input hi, input port, output hit);
endinterface

// ==== verilog/port_cmp.sv ====
/*
  One port filter: ignore, exact value, or inclusive range.
  Assumes the owner holds mode, bounds and port stable while hit is sampled.
*/
`timescale 1ns/1ps

module port_cmp (
  port_cmp_if.cmp pc
);
  import l4_match_pkg::*;

  function automatic logic in_range(input port_t p, input port_t lo, input port_t hi);
    in_range = (p >= lo) && (p <= hi);
  endfunction

  always_comb begin
    case (pc.mode)
      PORT_ANY:   pc.hit = 1'b1;
      PORT_EXACT: pc.hit = (pc.port == pc.lo);
      PORT_RANGE: pc.hit = in_range(pc.port, pc.lo, pc.hi);
      // the reserved code behaves as don't-care, so that a bad write cannot block all traffic
      default:    pc.hit = 1'b1;
    endcase
  end
endmodule

// ==== verif/l4_match_checker.sv ====
/* port checker for the layer-4 matcher.
   assumes it is bound to the top and sees only its ports. */
`timescale 1ns/1ps
`include "l4_match_defines.svh"
module l4_match_checker (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        frame_valid,
  input wire logic        match_valid,
  input wire logic        match_hit
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic rd;
  logic last_reg;
  assign rd = hsel && htrans[1] && !hwrite && hready;
  always_ff @(posedge mclk) begin
    if (!nrst) last_reg <= 1'b0;
    else if (match_valid) last_reg <= match_hit;
  end
  AST_ANSWER: assert property (frame_valid |=> match_valid)
    else $error("no result after frame");
  AST_ONLY: assert property (!frame_valid |=> !match_valid)
    else $error("result without frame");
  AST_HIT_QUAL: assert property (!match_valid |-> !match_hit)
    else $error("hit outside result");
  AST_READY: assert property (hreadyout)
    else $error("wait state inserted");
  AST_OKAY: assert property (!hresp)
    else $error("error response");
  AST_HOLD: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  AST_UNMAPPED: assert property (rd && haddr[7:0] > 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (rd && haddr[7:0] == `L4_OFF_STATUS && !match_valid
    |=> hrdata[0] == last_reg)
    else $error("status differs from last result");
  cover property (match_valid && match_hit);
  cover property (match_valid && !match_hit);
  cover property (rd && haddr[7:0] == `L4_OFF_STATUS);
endmodule
bind l4_port_flag_matcher l4_match_checker chk_i (
  .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .frame_valid(frame_valid), .match_valid(match_valid),
  .match_hit(match_hit)
);

// ==== verif/ingress_model.sv ====
/* ingress parser stand-in: presents one frame per call.
   assumes the caller waits for the result itself. */
`timescale 1ns/1ps
module ingress_model (
  input  wire logic  mclk,
  output logic       vld,
  output logic       tcp,
  output logic       udp,
  output logic [15:0] sp,
  output logic [15:0] dp,
  output logic       fin,
  output logic       syn,
  output logic       rst
);
  initial {vld, tcp, udp, sp, dp, fin, syn, rst} = '0;
  task automatic send(input logic [36:0] f);
    @(posedge mclk);
    vld <= 1'b1;
    {tcp, udp, sp, dp, fin, syn, rst} <= f;
    @(posedge mclk);
    vld <= 1'b0;
    // fields are not held once the frame is gone
    {tcp, udp, sp, dp, fin, syn, rst} <= ~f;
  endtask
endmodule

// ==== verif/l4_port_flag_matcher_tb.sv ====
/* self-checking bench for the layer-4 matcher.
   assumes the ingress model and the bound checker. */
`timescale 1ns/1ps
`include "l4_match_defines.svh"
module l4_port_flag_matcher_tb;
  logic mclk, nrst, hsel, hwrite, hreadyout, hresp, match_valid, match_hit;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        fv, tcp, udp, fin, syn, rst;
  logic [15:0] sp, dp;
  int fail_count, n_tests, hits;
  ingress_model fs (.mclk(mclk), .vld(fv), .tcp(tcp), .udp(udp), .sp(sp), .dp(dp),
    .fin(fin), .syn(syn), .rst(rst));
  l4_port_flag_matcher dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_valid(fv), .frame_is_tcp(tcp), .frame_is_udp(udp), .frame_src_port(sp),
    .frame_dst_port(dp), .frame_fin(fin), .frame_syn(syn), .frame_rst(rst),
    .match_valid(match_valid), .match_hit(match_hit));
  always #25 mclk = ~mclk;
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  function automatic logic [36:0] pf(input logic [1:0] k, input logic b, input logic [15:0] p);
    return b ? {k, 16'h1, p, 3'h0} : {k, p, 16'h1, 3'h0};
  endfunction
  task automatic frm(input logic [36:0] f, input logic e);
    fs.send(f);
    #1;
    chk({31'h0, match_valid}, 32'h1);
    chk({31'h0, match_hit}, {31'h0, e});
    hits += e;
  endtask
  task automatic t_reset;
    rd(`L4_OFF_CTRL, 32'h0);
    rd(`L4_OFF_SRC_PORT, 32'hFFFF_0000);
    rd(`L4_OFF_DST_PORT, 32'hFFFF_0000);
    rd(`L4_OFF_FLAGS, 32'h3F);
    rd(8'h18, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_port(input logic [7:0] off, input logic b);
    wr(`L4_OFF_CTRL, 32'h10);
    frm(pf(2'b10, b, 16'hFFFF), 1'b1);
    wr(`L4_OFF_CTRL, b ? 32'h14 : 32'h11);
    wr(off, 32'h0000_04D2);
    frm(pf(2'b10, b, 16'h04D2), 1'b1);
    frm(pf(2'b10, b, 16'h04D3), 1'b0);
    wr(`L4_OFF_CTRL, b ? 32'h18 : 32'h12);
    wr(off, 32'hFFFF_FFFE);
    frm(pf(2'b10, b, 16'hFFFF), 1'b1);
    frm(pf(2'b10, b, 16'hFFFD), 1'b0);
    wr(off, 32'h0005_0000);
    frm(pf(2'b10, b, 16'h0000), 1'b1);
    frm(pf(2'b10, b, 16'h0006), 1'b0);
    frm(pf(2'b01, b, 16'h0005), 1'b1);
    frm(pf(2'b00, b, 16'h0005), 1'b0);
    wr(`L4_OFF_CTRL, b ? 32'h1C : 32'h13);
    frm(pf(2'b00, b, 16'h0005), 1'b1);
    rd(`L4_OFF_STATUS, 32'h1);
    $display("port test done");
  endtask
  task automatic t_flags;
    wr(`L4_OFF_CTRL, 32'h10);
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 3; m++) begin
        wr(`L4_OFF_FLAGS, (32'h3F & ~(32'h3 << 2 * i)) | (m << 2 * i));
        for (int v = 0; v < 2; v++) begin
          frm(pf(2'b10, 1'b0, 16'h1) | 37'(v << (2 - i)), m == 2 || m == v);
        end
      end
    end
    wr(`L4_OFF_FLAGS, 32'h3D);
    frm(pf(2'b01, 1'b0, 16'h1), 1'b0);
    $display("flag test done");
  endtask
  task automatic t_off;
    wr(`L4_OFF_FLAGS, 32'h3F);
    wr(`L4_OFF_CTRL, 32'h0);
    frm(pf(2'b10, 1'b0, 16'h1), 1'b0);
    rd(`L4_OFF_STATUS, 32'h0);
    rd(`L4_OFF_COUNT, 32'(hits));
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(`L4_OFF_COUNT, 32'h0);
    rd(`L4_OFF_SRC_PORT, 32'hFFFF_0000);
    $display("disable test done");
  endtask
  initial begin
    {mclk, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    nrst = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_port(`L4_OFF_SRC_PORT, 1'b0);
    t_port(`L4_OFF_DST_PORT, 1'b1);
    t_flags;
    t_off;
    print_verdict;
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
endmodule
